// *** verilog/sba_pkg.sv ***
// Package for the 12-stage subtractive borrow adder.
// Assumes a single synchronous clock domain and no software registers.
package sba_pkg;
  localparam int unsigned WIDTH     = 12;
  localparam int unsigned GRP_SIZE  = 3;
  localparam int unsigned NUM_GRPS  = WIDTH / GRP_SIZE;
  localparam logic [11:0] ZERO_WORD = 12'h000;
  localparam logic [11:0] PLUS_ONE  = 12'h001;

  // Operand selections for the two operand sides.
  typedef enum logic [4:0] {
    CMD_A_PLUS_ONE   = 5'h00,
    CMD_A_PLUS_Z     = 5'h01,
    CMD_A_MINUS_Z    = 5'h02,
    CMD_Z_PLUS_ONE   = 5'h03,
    CMD_LOGICAL_PROD = 5'h04,
    CMD_SEL_COMPL    = 5'h05,
    CMD_REPLACE_ADD1 = 5'h06,
    CMD_XFER_A       = 5'h07,
    CMD_XFER_MINUS_Z = 5'h08,
    CMD_XFER_PLUS_Z  = 5'h09,
    CMD_SHIFT_LEFT   = 5'h0a
  } sba_cmd_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_CLEAR  = 2'b01,
    PH_TOGGLE = 2'b10,
    PH_PROBE  = 2'b11
  } sba_phase_t;

  typedef struct packed {
    sba_cmd_t    cmd;
    logic [11:0] accum;
    logic [11:0] memOp;
  } sba_req_t;
endpackage

// *** verilog/sba_adder.sv ***
// Subtractive one's-complement adder with clear, toggle and probe phases.
// Operands are captured at start and need not stay stable until done.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Both operand bits zero make stage borrow.
// - Unlike operand bits make stage enable.
// - Group borrow: borrow with higher enables.
// - Group enable when all stages enable.
// - Groups are three stages, one octal digit.
// - First phase clears result register.
// - Toggle phase sets bits of enabled stages.
// - Probe inverts bits not reached by borrow.
// - Passed borrow crosses intervening enabled stages.
// - Group borrow input from lower groups.
// - Top borrow wraps end-around to bottom.
// - Probe input blocked when borrow reaches stage.
// - Twelve stages, one input per side.
// - Input selections form the command set.
// - Arithmetic, transfer and shift commands supported.
// - Plus-one input drives ones except lowest.
// - Addition done by subtracting the complement.
module sba_adder
  import sba_pkg::*;
#(
  parameter int unsigned W = sba_pkg::WIDTH
) (
  input  wire logic            ref_clk,
  input  wire logic            reset,
  input  wire logic            start,
  input  wire sba_pkg::sba_req_t req,
  output logic [W-1:0]         result,
  output logic                 busy,
  output logic                 done
);
  import sba_pkg::*;

  // The borrow network is built for whole octal groups of the fixed word.
  if (W != WIDTH || W % GRP_SIZE != 0) begin : gBadWidth
    $error("sba_adder supports only the documented width");
  end

  sba_phase_t        phase_q, phase_d;
  sba_req_t          req_q;
  logic [W-1:0]      result_q, result_d;
  logic              done_q;

  // Operand sides hold true operand values; the R side feeds the adder
  // inverted, so R carries the subtrahend complement.
  logic [W-1:0]      rSide;
  logic [W-1:0]      qSide;
  logic [W-1:0]      rInv;
  // A +1 on the inverted R side puts ones into all but the lowest stage.
  wire  [W-1:0]      plusOneInv = ~PLUS_ONE;

  always_comb begin
    rSide = ZERO_WORD;
    qSide = req_q.accum;
    rInv  = ZERO_WORD;
    unique case (req_q.cmd)
      CMD_A_PLUS_ONE:   rSide = PLUS_ONE;
      CMD_A_PLUS_Z:     rSide = req_q.memOp;
      CMD_A_MINUS_Z:    rSide = ~req_q.memOp;
      CMD_Z_PLUS_ONE: begin
        rSide = req_q.memOp;
        qSide = PLUS_ONE;
      end
      CMD_LOGICAL_PROD: begin
        rSide = ZERO_WORD;
        qSide = req_q.accum & req_q.memOp;
      end
      CMD_SEL_COMPL: begin
        rSide = ZERO_WORD;
        qSide = req_q.accum ^ req_q.memOp;
      end
      CMD_REPLACE_ADD1: begin
        rSide = PLUS_ONE;
        qSide = req_q.memOp;
      end
      CMD_XFER_A:       rSide = ZERO_WORD;
      CMD_XFER_MINUS_Z: begin
        rSide = ~req_q.memOp;
        qSide = ZERO_WORD;
      end
      CMD_XFER_PLUS_Z: begin
        rSide = req_q.memOp;
        qSide = ZERO_WORD;
      end
      CMD_SHIFT_LEFT: begin
        rSide = ZERO_WORD;
        qSide = {req_q.accum[W-2:0], req_q.accum[W-1]};
      end
      default: begin
        rSide = ZERO_WORD;
        qSide = ZERO_WORD;
      end
    endcase
    rInv = ~rSide;
    if (req_q.cmd == CMD_A_PLUS_ONE || req_q.cmd == CMD_REPLACE_ADD1) begin
      rInv = plusOneInv;
    end
  end

  // Operands presented to each stage are the addend form.
  wire  [W-1:0] opA = qSide;
  wire  [W-1:0] opB = ~rInv;

  logic [W-1:0]        stageBorrow;
  logic [W-1:0]        stageEnable;
  logic [NUM_GRPS-1:0] groupBorrow;
  logic [NUM_GRPS-1:0] groupEnable;
  logic [NUM_GRPS-1:0] group_borrow_input_term;
  logic [W-1:0]        passed_borrow;
  logic [W-1:0]        stageProbe;

  assign stageBorrow = ~opA & ~opB;
  assign stageEnable = opA ^ opB;

  genvar g;
  generate
    for (g = 0; g < NUM_GRPS; g++) begin : gGrp
      localparam int unsigned L = g * GRP_SIZE;
      assign groupBorrow[g] = stageBorrow[L+2]
        | (stageBorrow[L+1] & stageEnable[L+2])
        | (stageBorrow[L] & stageEnable[L+1] & stageEnable[L+2]);
      assign groupEnable[g] = &stageEnable[L+2:L];
      // Borrow into a group comes from the adjacent lower group, through
      // enabled groups from farther down, and end-around from the top.
      always_comb begin
        logic pend;
        pend = 1'b0;
        for (int k = 1; k <= NUM_GRPS; k++) begin
          pend = pend | (groupBorrow[(g + NUM_GRPS - k) % NUM_GRPS]
                 & ((k == 1) | passAll(g, k)));
        end
        group_borrow_input_term[g] = pend;
      end
      // Borrow reaching a stage inside a group.
      assign passed_borrow[L]   = group_borrow_input_term[g];
      assign passed_borrow[L+1] = stageBorrow[L]
        | (group_borrow_input_term[g] & stageEnable[L]);
      assign passed_borrow[L+2] = stageBorrow[L+1]
        | (stageBorrow[L] & stageEnable[L+1])
        | (group_borrow_input_term[g] & stageEnable[L] & stageEnable[L+1]);
    end
  endgenerate

  // True when every group between source (g-k) and g exclusive is enabled.
  function automatic logic passAll(input int gi, input int k);
    logic ok;
    ok = 1'b1;
    for (int j = 1; j < NUM_GRPS; j++) begin
      if (j < k) ok = ok & groupEnable[(gi + NUM_GRPS - j) % NUM_GRPS];
    end
    return ok;
  endfunction

  assign stageProbe = ~passed_borrow;

  always_comb begin
    phase_d  = phase_q;
    result_d = result_q;
    unique case (phase_q)
      PH_IDLE: if (start) phase_d = PH_CLEAR;
      PH_CLEAR: begin
        result_d = ZERO_WORD;
        phase_d  = PH_TOGGLE;
      end
      PH_TOGGLE: begin
        result_d = result_q | stageEnable;
        phase_d  = PH_PROBE;
      end
      PH_PROBE: begin
        result_d = result_q ^ stageProbe;
        phase_d  = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_q  <= PH_IDLE;
      result_q <= ZERO_WORD;
      done_q   <= 1'b0;
      req_q    <= '0;
    end else begin
      phase_q  <= phase_d;
      result_q <= result_d;
      done_q   <= (phase_q == PH_PROBE);
      if (phase_q == PH_IDLE && start) req_q <= req;
    end
  end

  assign result = result_q;
  assign done   = done_q;

  logic busy_q;
  always_ff @(posedge ref_clk) begin
    if (reset) busy_q <= 1'b0;
    else busy_q <= (phase_d != PH_IDLE);
  end
  assign busy = busy_q;
endmodule

`default_nettype wire

// *** testbench/sba_adder_props.sv ***
// Port checker for the subtractive borrow adder.
// Assumes a bind from the bench top onto sba_adder.
`timescale 1ns/10ps
`default_nettype none
module sba_props
  import sba_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire logic              start,
  input wire sba_pkg::sba_req_t req,
  input wire logic [11:0]       result,
  input wire logic              busy,
  input wire logic              done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire take = start && !busy;
  sba_req_t capQ;
  always_ff @(posedge ref_clk) if (take) capQ <= req;
  busy_len_a: assert property (take |=> busy [*3] ##1 (!busy && done))
    else $error("busy or done timing wrong");
  clear_ph_a: assert property (take |-> ##2 result == 12'h000)
    else $error("result not cleared");
  tog_add_a: assert property (take && req.cmd == CMD_A_PLUS_Z |->
    ##3 result == (capQ.accum ^ capQ.memOp)) else $error("toggle wrong on add");
  tog_sub_a: assert property (take && req.cmd == CMD_A_MINUS_Z |->
    ##3 result == ~(capQ.accum ^ capQ.memOp)) else $error("toggle wrong on subtract");
  done_one_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  busy_cause_a: assert property ($rose(busy) |-> $past(start))
    else $error("busy without start");
  busy_end_a: assert property ($fell(busy) && !$past(reset) |-> done)
    else $error("busy fell without done");
  hold_res_a: assert property (!busy |=> $stable(result))
    else $error("result moved while idle");
endmodule
`default_nettype wire

// *** testbench/tb_sba_adder.sv ***
// Self-checking bench for the subtractive borrow adder.
// Assumes sba_pkg and sba_adder are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nErrors++; \
  $display("unexpected at %0t: got %h", $time, g); end end
module tb_sba_adder;
  import sba_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  sba_req_t    req = '0;
  logic [11:0] result;
  logic        busy;
  logic        done;
  int          nErrors = 0;
  int          nTests = 0;
  always #25 clk = ~clk;
  sba_adder sba_adder_inst (.ref_clk(clk), .reset(rst), .start(start), .req(req),
    .result(result), .busy(busy), .done(done));
  task automatic endSim;
    $display("errors %0d tests %0d", nErrors, nTests);
    if (nErrors == 0 && nTests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic run(sba_cmd_t c, logic [11:0] a, z, e, bit k = 1);
    @(negedge clk);
    req = {c, a, z};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (8) if (!done) @(negedge clk);
    if (k) `CHK(result, e)
    `CHK(done, 1'b1)
  endtask
  task automatic tAdd;
    run(CMD_A_PLUS_Z, 12'h123, 12'h456, 12'h579);
    run(CMD_A_PLUS_Z, 12'h7ff, 12'h001, 12'h800);
    run(CMD_A_PLUS_Z, 12'h038, 12'h009, 12'h041);
    run(CMD_A_PLUS_Z, 12'h005, 12'hffa, 12'h000);
  endtask
  task automatic tSub;
    run(CMD_A_MINUS_Z, 12'h100, 12'h001, 12'h0ff);
    run(CMD_A_MINUS_Z, 12'h001, 12'h003, 12'hffd);
  endtask
  task automatic tCmds;
    run(CMD_A_PLUS_ONE, 12'h3ff, 12'h000, 12'h400);
    run(CMD_Z_PLUS_ONE, 12'h000, 12'h0ff, 12'h100);
    run(CMD_LOGICAL_PROD, 12'h5a3, 12'h3c6, 12'h182);
    run(CMD_SEL_COMPL, 12'h5a3, 12'h3c6, 12'h665);
    run(CMD_XFER_A, 12'h5a3, 12'h3c6, 12'h5a3);
    run(CMD_XFER_PLUS_Z, 12'h5a3, 12'h3c6, 12'h3c6);
    run(CMD_XFER_MINUS_Z, 12'h5a3, 12'h3c6, 12'hc39);
    run(CMD_SHIFT_LEFT, 12'h8a3, 12'h000, 12'h147);
    run(CMD_REPLACE_ADD1, 12'h5a3, 12'h3c6, 12'h3c7);
  endtask
  task automatic tRefuse;
    @(negedge clk);
    req = {CMD_A_PLUS_Z, 12'h111, 12'h222};
    start = 1'b1;
    @(negedge clk);
    req = {CMD_XFER_A, 12'h0aa, 12'h0aa};
    repeat (3) @(negedge clk);
    start = 1'b0;
    repeat (4) if (!done) @(negedge clk);
    `CHK(result, 12'h333)
  endtask
  task automatic tReset;
    @(negedge clk);
    req = {CMD_A_PLUS_Z, 12'h111, 12'h222};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    `CHK({result, busy}, 13'h0000)
    run(CMD_A_PLUS_Z, 12'h111, 12'h222, 12'h333);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    tAdd;
    tSub;
    tCmds;
    tRefuse;
    tReset;
    endSim;
  end
  initial begin
    #100us;
    nErrors++;
    endSim;
  end
endmodule
bind sba_adder sba_props sba_props_inst (.ref_clk(ref_clk), .reset(reset), .start(start),
  .req(req), .result(result), .busy(busy), .done(done));
`default_nettype wire
